/* design/pbsr_regs.svh */
// register offsets, bit positions, frame constants and reset values of the basic status block
`ifndef PBSR_REGS_SVH
`define PBSR_REGS_SVH

// ==========================================================
// register map
`define PBSR_BASIC_STATUS_ADDR 5'h01
`define PBSR_ESTATUS_ADDR 5'h0F
`define PBSR_WORD_W 16
`define PBSR_WORD_RST 16'h0000

// ==========================================================
// basic_status bit positions
`define PBSR_BIT_T4 15
`define PBSR_BIT_TX_FD 14
`define PBSR_BIT_TX_HD 13
`define PBSR_BIT_TE_FD 12
`define PBSR_BIT_TE_HD 11
`define PBSR_BIT_T2_FD 10
`define PBSR_BIT_T2_HD 9
`define PBSR_BIT_EXT_STATUS 8
`define PBSR_BIT_RSVD 7
`define PBSR_BIT_NO_PRE 6
`define PBSR_BIT_AN_DONE 5
`define PBSR_BIT_RFAULT 4
`define PBSR_BIT_AN_ABLE 3
`define PBSR_BIT_LINK 2
`define PBSR_BIT_JABBER 1
`define PBSR_BIT_EXT_CAP 0

// ==========================================================
// latched status cells: index 0 fault, 1 jabber, 2 link loss
`define PBSR_NLATCH 3
`define PBSR_LAT_FAULT 0
`define PBSR_LAT_JABBER 1
`define PBSR_LAT_LINK 2
`define PBSR_LAT_RST 3'h4

// ==========================================================
// management frame layout
`define PBSR_PRE_LEN 6'h20
`define PBSR_PRE_CNT_W 6
`define PBSR_OP_READ 2'h2
`define PBSR_OP_WRITE 2'h1
`define PBSR_OP_LAST 5'h01
`define PBSR_ADDR_LAST 5'h09
`define PBSR_TA_LAST 5'h01
`define PBSR_DATA_LAST 5'h0F
`define PBSR_CNT_ZERO 5'h00
`define PBSR_CNT_ONE 5'h01

`endif

/* design/pbsr_pkg.sv */
// types shared by the basic status block
package pbsr_pkg;

  // ==========================================================
  // management frame sequencer
  typedef enum logic [2:0] {
    PBSR_S_PRE,
    PBSR_S_ST,
    PBSR_S_OP,
    PBSR_S_ADDR,
    PBSR_S_TA,
    PBSR_S_DATA
  } pbsr_state_t;

endpackage : pbsr_pkg

/* design/pbsr_sticky.sv */
// one latched status cell: set by an event, released by a register read
`timescale 1ns/100ps

module pbsr_sticky #(
  parameter logic RST_VAL = 1'b0
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic set,
  input wire logic clr,
  output logic q
);

  // ==========================================================
  // set wins over clear so an event in the read cycle is kept
  always_ff @(posedge clk) begin
    if (!nrst) begin
      q <= RST_VAL;
    end else begin
      q <= set | (q & ~clr);
    end
  end

endmodule : pbsr_sticky

/* design/pbsr_mdc_edge.sv */
// management clock edge finder and data sampler
`timescale 1ns/100ps

module pbsr_mdc_edge (
  input wire logic clk,
  input wire logic nrst,
  input wire logic mdc,
  input wire logic mdio_in,
  output logic mdc_rise,
  output logic mdio_bit
);

  logic mdc_q;

  // ==========================================================
  // the pin is tracked through reset, so a clock resting high gives no false edge on release
  always_ff @(posedge clk) begin
    mdc_q <= mdc;
  end

  // both outputs registered together so the bit lines up with its edge
  always_ff @(posedge clk) begin
    if (!nrst) begin
      mdc_rise <= 1'b0;
      mdio_bit <= 1'b1;
    end else begin
      mdc_rise <= mdc & ~mdc_q;
      mdio_bit <= mdio_in;
    end
  end

endmodule : pbsr_mdc_edge

/* design/pbsr_top.sv */
// basic status register of the transceiver with its serial management slave
`timescale 1ns/100ps
`include "pbsr_regs.svh"

module pbsr_top (
  input wire logic clk,
  input wire logic nrst,
  input wire logic mdc,
  input wire logic mdio_in,
  output logic mdio_out,
  output logic mdio_oe,
  input wire logic [4:0] phy_addr,
  input wire logic an_complete,
  input wire logic link_good,
  input wire logic far_end_fault,
  input wire logic remote_fault_rx,
  input wire logic jabber,
  input wire logic speed_10
);

  import pbsr_pkg::*;

  // ==========================================================
  // declarations
  logic mdc_rise;
  logic mdio_bit;
  pbsr_state_t state;
  logic [`PBSR_PRE_CNT_W-1:0] pre_cnt;
  logic [4:0] bit_cnt;
  logic [1:0] op;
  logic [9:0] addr_sh;
  logic [9:0] next_addr;
  logic [1:0] next_op;
  logic is_read;
  logic answer;
  logic need_pre;
  logic bad_frame;
  logic frame_done;
  logic take_read;
  logic rd_pulse;
  logic [`PBSR_WORD_W-1:0] shadow;
  logic [`PBSR_WORD_W-1:0] status_word;
  logic an_done;
  logic [`PBSR_NLATCH-1:0] lat_set;
  logic [`PBSR_NLATCH-1:0] lat_q;
  logic [4:0] rx_phy;
  logic [4:0] rx_reg;
  logic reg_hit;

  // ==========================================================
  // management clock edge and data sampling
  pbsr_mdc_edge u_edge (
    .clk(clk),
    .nrst(nrst),
    .mdc(mdc),
    .mdio_in(mdio_in),
    .mdc_rise(mdc_rise),
    .mdio_bit(mdio_bit)
  );

  // ==========================================================
  // frame field decode
  assign next_addr = {addr_sh[8:0], mdio_bit};
  assign next_op = {op[0], mdio_bit};
  assign is_read = (op == `PBSR_OP_READ);
  // address field: device number in the upper five bits, register in the lower five
  assign rx_phy = next_addr[9:5];
  assign rx_reg = next_addr[4:0];
  assign reg_hit = (rx_reg == `PBSR_BASIC_STATUS_ADDR);

  // a read of our address finishes its address field on this edge
  assign take_read = mdc_rise && (state == PBSR_S_ADDR) && (bit_cnt == `PBSR_ADDR_LAST)
                     && is_read && (rx_phy == phy_addr);

  // invalid opcode, or a write turnaround that is not one then zero
  // the read turnaround is not checked, as the host has already let go of the line
  always_comb begin
    bad_frame = 1'b0;
    if (mdc_rise) begin
      if ((state == PBSR_S_OP) && (bit_cnt == `PBSR_OP_LAST)) begin
        bad_frame = (next_op != `PBSR_OP_READ) && (next_op != `PBSR_OP_WRITE);
      end else if ((state == PBSR_S_TA) && !is_read) begin
        bad_frame = (bit_cnt == `PBSR_CNT_ZERO) ? !mdio_bit : mdio_bit;
      end
    end
  end

  assign frame_done = mdc_rise && (state == PBSR_S_DATA) && (bit_cnt == `PBSR_DATA_LAST);

  // ==========================================================
  // frame sequencer
  always_ff @(posedge clk) begin
    if (!nrst) begin
      state <= PBSR_S_PRE;
      bit_cnt <= `PBSR_CNT_ZERO;
      op <= 2'h0;
      addr_sh <= 10'h000;
    end else if (mdc_rise) begin
      unique case (state)
        PBSR_S_PRE: begin
          // an idle line is all ones; a zero is the first start bit
          if (!mdio_bit && (!need_pre || (pre_cnt >= `PBSR_PRE_LEN))) begin
            state <= PBSR_S_ST;
          end
        end
        PBSR_S_ST: begin
          state <= mdio_bit ? PBSR_S_OP : PBSR_S_PRE;
          bit_cnt <= `PBSR_CNT_ZERO;
        end
        PBSR_S_OP: begin
          op <= next_op;
          if (bit_cnt == `PBSR_OP_LAST) begin
            state <= bad_frame ? PBSR_S_PRE : PBSR_S_ADDR;
            bit_cnt <= `PBSR_CNT_ZERO;
          end else begin
            bit_cnt <= bit_cnt + `PBSR_CNT_ONE;
          end
        end
        PBSR_S_ADDR: begin
          addr_sh <= next_addr;
          if (bit_cnt == `PBSR_ADDR_LAST) begin
            state <= PBSR_S_TA;
            bit_cnt <= `PBSR_CNT_ZERO;
          end else begin
            bit_cnt <= bit_cnt + `PBSR_CNT_ONE;
          end
        end
        PBSR_S_TA: begin
          if (bad_frame) begin
            state <= PBSR_S_PRE;
            bit_cnt <= `PBSR_CNT_ZERO;
          end else if (bit_cnt == `PBSR_TA_LAST) begin
            state <= PBSR_S_DATA;
            bit_cnt <= `PBSR_CNT_ZERO;
          end else begin
            bit_cnt <= bit_cnt + `PBSR_CNT_ONE;
          end
        end
        PBSR_S_DATA: begin
          if (bit_cnt == `PBSR_DATA_LAST) begin
            state <= PBSR_S_PRE;
            bit_cnt <= `PBSR_CNT_ZERO;
          end else begin
            bit_cnt <= bit_cnt + `PBSR_CNT_ONE;
          end
        end
        // an upset into an unused code drops back to idle
        default: begin
          state <= PBSR_S_PRE;
          bit_cnt <= `PBSR_CNT_ZERO;
        end
      endcase
    end
  end

  // ==========================================================
  // preamble counting; saturates so a long idle line still counts
  always_ff @(posedge clk) begin
    if (!nrst) begin
      pre_cnt <= '0;
    end else if (mdc_rise) begin
      if ((state == PBSR_S_PRE) && mdio_bit) begin
        if (pre_cnt < `PBSR_PRE_LEN) begin
          pre_cnt <= pre_cnt + `PBSR_PRE_CNT_W'(1);
        end
      end else begin
        pre_cnt <= '0;
      end
    end
  end

  // ==========================================================
  // preamble demand: set by reset and bad frames, dropped by a clean frame
  always_ff @(posedge clk) begin
    if (!nrst) begin
      need_pre <= 1'b1;
    end else if (bad_frame) begin
      need_pre <= 1'b1;
    end else if (frame_done) begin
      need_pre <= 1'b0;
    end
  end

  // ==========================================================
  // live status word as seen at the moment of a read
  always_comb begin
    status_word = `PBSR_WORD_RST;
    status_word[`PBSR_BIT_T4] = 1'b0;
    status_word[`PBSR_BIT_T2_FD] = 1'b0;
    status_word[`PBSR_BIT_T2_HD] = 1'b0;
    status_word[`PBSR_BIT_TX_FD] = 1'b1;
    status_word[`PBSR_BIT_TX_HD] = 1'b1;
    status_word[`PBSR_BIT_TE_FD] = 1'b1;
    status_word[`PBSR_BIT_TE_HD] = 1'b1;
    status_word[`PBSR_BIT_EXT_STATUS] = 1'b1;
    status_word[`PBSR_BIT_RSVD] = 1'b0;
    status_word[`PBSR_BIT_NO_PRE] = 1'b1;
    status_word[`PBSR_BIT_AN_DONE] = an_done;
    status_word[`PBSR_BIT_RFAULT] = lat_q[`PBSR_LAT_FAULT];
    status_word[`PBSR_BIT_AN_ABLE] = 1'b1;
    status_word[`PBSR_BIT_LINK] = ~lat_q[`PBSR_LAT_LINK];
    status_word[`PBSR_BIT_JABBER] = lat_q[`PBSR_LAT_JABBER];
    status_word[`PBSR_BIT_EXT_CAP] = 1'b1;
  end

  // ==========================================================
  // auto-negotiation completion, zero out of reset
  always_ff @(posedge clk) begin
    if (!nrst) begin
      an_done <= 1'b0;
    end else begin
      an_done <= an_complete;
    end
  end

  // ==========================================================
  // latched status cells; link loss is kept as a latched-high failure
  assign lat_set[`PBSR_LAT_FAULT] = far_end_fault | remote_fault_rx;
  assign lat_set[`PBSR_LAT_JABBER] = jabber & speed_10;
  assign lat_set[`PBSR_LAT_LINK] = ~link_good;
  // the link cell holds a failure, so it starts set and the link bit reads zero
  localparam logic [`PBSR_NLATCH-1:0] LAT_RST = `PBSR_LAT_RST;

  genvar gi;
  generate
    for (gi = 0; gi < `PBSR_NLATCH; gi++) begin : g_lat
      pbsr_sticky #(
        .RST_VAL(LAT_RST[gi])
      ) u_cell (
        .clk(clk),
        .nrst(nrst),
        .set(lat_set[gi]),
        .clr(rd_pulse),
        .q(lat_q[gi])
      );
    end
  endgenerate

  // ==========================================================
  // read capture: snapshot first, release the latches one cycle later
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rd_pulse <= 1'b0;
    end else begin
      rd_pulse <= take_read && reg_hit;
    end
  end

  // ==========================================================
  // answer flag: only a read of our address drives the line
  always_ff @(posedge clk) begin
    if (!nrst) begin
      answer <= 1'b0;
    end else if (take_read) begin
      answer <= 1'b1;
    end else if (frame_done || (state == PBSR_S_PRE)) begin
      answer <= 1'b0;
    end
  end

  // ==========================================================
  // read data shifter and line driver
  always_ff @(posedge clk) begin
    if (!nrst) begin
      shadow <= `PBSR_WORD_RST;
      mdio_out <= 1'b0;
      mdio_oe <= 1'b0;
    end else if (take_read) begin
      // other registers of this address are not kept here and read as zero
      shadow <= reg_hit ? status_word : `PBSR_WORD_RST;
    end else if (mdc_rise && answer) begin
      if ((state == PBSR_S_TA) && (bit_cnt == `PBSR_CNT_ZERO)) begin
        // second turnaround bit is driven low by us
        mdio_out <= 1'b0;
        mdio_oe <= 1'b1;
      end else if ((state == PBSR_S_DATA) && (bit_cnt == `PBSR_DATA_LAST)) begin
        // the rise after bit 0 lets go of the line so the host can take it back
        mdio_out <= 1'b0;
        mdio_oe <= 1'b0;
      end else if ((state == PBSR_S_TA) || (state == PBSR_S_DATA)) begin
        mdio_out <= shadow[`PBSR_WORD_W-1];
        shadow <= {shadow[`PBSR_WORD_W-2:0], 1'b0};
      end
    end
  end

endmodule : pbsr_top

/* tb/pbsr_top_checker.sv */
// assertions on the serial answer of the basic status block
`timescale 1ns/100ps

module pbsr_top_checker (
  input wire logic clk,
  input wire logic nrst,
  input wire logic mdc,
  input wire logic mdio_in,
  input wire logic mdio_out,
  input wire logic mdio_oe,
  input wire logic [4:0] phy_addr,
  input wire logic an_complete,
  input wire logic link_good,
  input wire logic far_end_fault,
  input wire logic remote_fault_rx,
  input wire logic jabber,
  input wire logic speed_10
);
  // ==========================================================
  // bit tracking: idx counts clock rises while the answer is driven
  logic mdc_q;
  logic oe_q;
  logic reg1;
  logic [5:0] sh;
  logic [4:0] idx;
  logic hit;
  assign hit = mdc && !mdc_q && mdio_oe && reg1;
  always_ff @(posedge clk) begin
    mdc_q <= mdc;
    oe_q <= mdio_oe;
    if (mdc && !mdc_q) begin
      sh <= {sh[4:0], mdio_in};
    end
  end
  // register number sits just before the first turnaround bit
  always_ff @(posedge clk) begin
    if (!nrst || !mdio_oe) begin
      idx <= 5'h00;
    end else if (mdc && !mdc_q) begin
      idx <= idx + 5'h01;
    end
    if (mdio_oe && !oe_q) begin
      reg1 <= (sh[5:1] == 5'h01);
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // ==========================================================
  // fixed and live bits of each answer
  property p_zero;
    hit && idx inside {5'h01, 5'h06, 5'h07} |-> !mdio_out;
  endproperty
  a_zero: assert property (p_zero) else $error("unsupported mode bit high");
  property p_abil;
    hit && idx inside {[5'h02:5'h05]} |-> mdio_out;
  endproperty
  a_abil: assert property (p_abil) else $error("speed ability bit low");
  property p_ext;
    hit && idx == 5'h08 |-> mdio_out;
  endproperty
  a_ext: assert property (p_ext) else $error("extended status bit low");
  property p_rsvd;
    hit && idx == 5'h09 |-> !mdio_out;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bit high");
  property p_nopre;
    hit && idx == 5'h0A |-> mdio_out[*2];
  endproperty
  a_nopre: assert property (p_nopre) else $error("preamble ability bit low");
  property p_an;
    hit && idx == 5'h0B |-> mdio_out == an_complete;
  endproperty
  a_an: assert property (p_an) else $error("negotiation done bit wrong");
  property p_anab;
    hit && idx == 5'h0D |-> mdio_out;
  endproperty
  a_anab: assert property (p_anab) else $error("negotiation ability bit low");
  property p_extcap;
    hit && idx == 5'h10 |-> mdio_out ##[1:4] !mdio_oe;
  endproperty
  a_extcap: assert property (p_extcap) else $error("last bit low or drive kept");
endmodule : pbsr_top_checker

bind pbsr_top pbsr_top_checker u_pbsr_top_checker (
  .clk(clk), .nrst(nrst), .mdc(mdc), .mdio_in(mdio_in), .mdio_out(mdio_out),
  .mdio_oe(mdio_oe), .phy_addr(phy_addr), .an_complete(an_complete),
  .link_good(link_good), .far_end_fault(far_end_fault),
  .remote_fault_rx(remote_fault_rx), .jabber(jabber), .speed_10(speed_10)
);

/* tb/pbsr_mgmt_model.sv */
// station management controller model for the serial management line
`timescale 1ns/100ps

module pbsr_mgmt_model (
  input wire logic clk,
  input wire logic line,
  output logic mdc,
  output logic host_oe,
  output logic host_out
);
  initial begin
    {mdc, host_oe, host_out} = 3'h0;
  end
  // ==========================================================
  // one bit: four clocks low, four high; the line is sampled at the rise
  task automatic cyc(input logic oe, input logic b, output logic s);
    @(posedge clk) #1;
    {mdc, host_oe, host_out} = {1'b0, oe, b};
    repeat (4) @(posedge clk);
    #1;
    s = line;
    mdc = 1'b1;
    repeat (3) @(posedge clk);
  endtask : cyc
  // a read releases the line from the turnaround on; mdc then rests high
  task automatic frame(input int npre, input logic [13:0] hdr, input logic [1:0] ta,
                       input logic [15:0] wd, output logic [15:0] rd);
    logic s;
    logic rel;
    rel = (hdr[11:10] == 2'h2);
    for (int i = 0; i < npre; i++) cyc(1'b1, 1'b1, s);
    for (int i = 13; i >= 0; i--) cyc(1'b1, hdr[i], s);
    for (int i = 1; i >= 0; i--) cyc(!rel, ta[i], s);
    for (int i = 15; i >= 0; i--) begin
      cyc(!rel, wd[i], s);
      rd[i] = s;
    end
    @(posedge clk) #1;
    host_oe = 1'b0;
  endtask : frame
endmodule : pbsr_mgmt_model

/* tb/tb.sv */
// self-checking bench for the basic status block
`timescale 1ns/100ps

`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin err_count++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end

module tb;
  localparam logic [4:0] PA = 5'h0B;
  logic clk, nrst, an_complete, link_good, far_end_fault, remote_fault_rx, jabber, speed_10;
  logic mdc, mdio_out, mdio_oe, host_oe, host_out, mdio_line;
  logic [15:0] v;
  int checks;
  int err_count;
  // an, link, fault, remote fault, jabber, 10M, first read, second read
  logic [37:0] rows [7] = '{{6'h10, 16'h7949, 16'h794D}, {6'h38, 16'h797D, 16'h796D},
    {6'h34, 16'h797D, 16'h796D}, {6'h13, 16'h794F, 16'h794D}, {6'h12, 16'h794D, 16'h794D},
    {6'h00, 16'h7949, 16'h7949}, {6'h10, 16'h7949, 16'h794D}};
  // released line floats to its pull-up level
  assign mdio_line = mdio_oe ? mdio_out : (host_oe ? host_out : 1'b1);
  pbsr_top u_pbsr_top (
    .clk(clk), .nrst(nrst), .mdc(mdc), .mdio_in(mdio_line), .mdio_out(mdio_out),
    .mdio_oe(mdio_oe), .phy_addr(PA), .an_complete(an_complete), .link_good(link_good),
    .far_end_fault(far_end_fault), .remote_fault_rx(remote_fault_rx), .jabber(jabber),
    .speed_10(speed_10)
  );
  pbsr_mgmt_model u_pbsr_mgmt_model (
    .clk(clk), .line(mdio_line), .mdc(mdc), .host_oe(host_oe), .host_out(host_out)
  );
  // ==========================================================
  // tasks
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic rd(input int np, input logic [4:0] ra, output logic [15:0] d);
    u_pbsr_mgmt_model.frame(np, {4'h6, PA, ra}, 2'h0, 16'h0000, d);
  endtask : rd
  task automatic close_out;
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : close_out
  // ==========================================================
  // clock, watchdog, main sequence
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    tick(60000);
    err_count++;
    close_out();
  end
  initial begin
    {nrst, an_complete, link_good, far_end_fault, remote_fault_rx, jabber, speed_10} = 7'h00;
    checks = 0;
    err_count = 0;
    tick(12);
    nrst = 1'b1;
    tick(2);
    foreach (rows[i]) begin
      {an_complete, link_good, speed_10} = {rows[i][37:36], rows[i][32]};
      tick(1);
      {far_end_fault, remote_fault_rx, jabber} = rows[i][35:33];
      tick(1);
      {far_end_fault, remote_fault_rx, jabber} = 3'h0;
      rd(32, 5'h01, v);
      `CHK("first read", rows[i][31:16], v)
      rd(0, 5'h01, v);
      `CHK("second read", rows[i][15:0], v)
    end
    rd(32, 5'h02, v);
    `CHK("unmapped register", 16'h0000, v)
    u_pbsr_mgmt_model.frame(32, {4'h6, 5'h0C, 5'h01}, 2'h0, 16'h0000, v);
    `CHK("foreign address", 16'hFFFF, v)
    // event in the very cycle the read releases the latches must survive it
    fork
      rd(32, 5'h01, v);
      begin
        tick(367);
        far_end_fault = 1'b1;
        tick(1);
        far_end_fault = 1'b0;
      end
    join
    `CHK("read during event", 16'h794D, v)
    rd(0, 5'h01, v);
    `CHK("late event kept", 16'h795D, v)
    u_pbsr_mgmt_model.frame(32, {4'h5, PA, 5'h01}, 2'h2, 16'h0000, v);
    rd(0, 5'h01, v);
    `CHK("write ignored", 16'h794D, v)
    for (int k = 0; k < 2; k++) begin
      u_pbsr_mgmt_model.frame(32, {(k == 0) ? 4'h7 : 4'h5, PA, 5'h01}, 2'h0, 16'h0000, v);
      rd(0, 5'h01, v);
      `CHK("bad frame then bare start", 16'hFFFF, v)
      rd(32, 5'h01, v);
      `CHK("preamble restores", 16'h794D, v)
    end
    speed_10 = 1'b1;
    {remote_fault_rx, jabber} = 2'h3;
    tick(1);
    {remote_fault_rx, jabber} = 2'h0;
    nrst = 1'b0;
    tick(3);
    nrst = 1'b1;
    tick(2);
    rd(0, 5'h01, v);
    `CHK("bare start after reset", 16'hFFFF, v)
    rd(32, 5'h01, v);
    `CHK("after reset", 16'h7949, v)
    close_out();
  end
endmodule : tb
